/* File: nxe_pkg.sv */
// Constants, opcode patterns and enumerations shared by the exchange and xor datapath.
// Assumes a single core clock and a synchronous active-high reset in every user.
package nxe_pkg;

	// ----------------------------------------------------------------
	// Opcode patterns
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_SBW_IMM = 8'h94;
	localparam logic [7:0] OPC_SWAP = 8'hc4;
	localparam logic [7:0] OPC_EXB_REG = 8'hc8;
	localparam logic [7:0] OPC_EXB_DIR = 8'hc5;
	localparam logic [7:0] OPC_EXB_IND = 8'hc6;
	localparam logic [7:0] OPC_EXD = 8'hd6;
	localparam logic [7:0] OPC_XOR_REG = 8'h68;
	localparam logic [7:0] OPC_XOR_DIR = 8'h65;
	localparam logic [7:0] OPC_XOR_IND = 8'h66;
	localparam logic [7:0] OPC_XOR_IMM = 8'h64;
	localparam logic [7:0] OPC_XOR_DA = 8'h62;
	localparam logic [7:0] OPC_XOR_DI = 8'h63;

	// ----------------------------------------------------------------
	// Memory map and reset values
	// ----------------------------------------------------------------
	localparam int RAM_AW = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] PORT_ADDR = 8'h90;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'hff;

	// Instruction kinds after decode
	typedef enum logic [3:0] {
		K_SBW_IMM, K_SWAP, K_EXB_REG, K_EXB_DIR, K_EXB_IND, K_EXD,
		K_XOR_REG, K_XOR_DIR, K_XOR_IND, K_XOR_IMM, K_XOR_DA, K_XOR_DI, K_BAD
	} nxe_kind_e;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE, ST_PTR, ST_EXEC, ST_FIN
	} nxe_state_e;

endpackage

/* File: nxe_ram.sv */
// Internal data memory: one synchronous read port with registered data, one write port.
// Assumes the caller never needs read-during-write forwarding on the same address.
`timescale 1ns/1ns
module nxe_ram #(
	parameter int AW = nxe_pkg::RAM_AW,
	parameter int DW = nxe_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd_en,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Array carries no reset so it maps to plain RAM cells
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data held in a register until the next read
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd_en) begin
			rdata <= mem[raddr];
		end
	end

endmodule

/* File: nxe_exec.sv */
// Execution datapath for borrow subtract, nibble swap, exchanges and exclusive-OR.
// Assumes the fetch logic presents opcode and following bytes together with a start pulse.
// What this block does
// - Immediate borrow subtract, two bytes, one cycle: acc gets acc minus carry minus data.
// - Borrow subtract sets carry, aux carry on bit 3 borrow, overflow on bit 6/7 mismatch.
// - Nibble swap exchanges accumulator halves, one byte, one cycle, flags untouched.
// - Byte exchange loads acc from operand and writes old acc back to it.
// - Register byte exchange opcode low three bits pick one of eight bank registers.
// - Digit exchange swaps low nibbles of acc and indirect RAM byte, flags untouched.
// - Exclusive-OR stores result in destination, no flags change, six operand combinations.
// - Exclusive-OR into an output port reads the output latch; the direct-source form reads the pins.
// - Direct-destination exclusive-OR complements bits by constant or accumulator mask.
// - Register exclusive-OR opcode low three bits pick bank register combined into acc.
// - Direct-source exclusive-OR is two bytes and XORs addressed byte into acc.
`timescale 1ns/1ns
module nxe_exec #(
	parameter logic [7:0] PORT_ADDR = nxe_pkg::PORT_ADDR
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand1,
	input wire logic [7:0] operand2,
	input wire logic ld_en,
	input wire logic [7:0] ld_acc,
	input wire logic ld_carry,
	input wire logic [7:0] port_pins,
	output logic busy,
	output logic done,
	output logic illegal,
	output logic [7:0] acc,
	output logic carry,
	output logic aux_carry_flag,
	output logic overflow_flag,
	output logic [7:0] port_out,
	output logic [1:0] instr_bytes,
	output logic [1:0] instr_cycles
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic nxe_pkg::nxe_kind_e decode_kind(input logic [7:0] op);
		nxe_pkg::nxe_kind_e k;
		k = nxe_pkg::K_BAD;
		if (op == nxe_pkg::OPC_SBW_IMM) k = nxe_pkg::K_SBW_IMM;
		else if (op == nxe_pkg::OPC_SWAP) k = nxe_pkg::K_SWAP;
		else if (op[7:3] == nxe_pkg::OPC_EXB_REG[7:3]) k = nxe_pkg::K_EXB_REG;
		else if (op == nxe_pkg::OPC_EXB_DIR) k = nxe_pkg::K_EXB_DIR;
		else if (op[7:1] == nxe_pkg::OPC_EXB_IND[7:1]) k = nxe_pkg::K_EXB_IND;
		else if (op[7:1] == nxe_pkg::OPC_EXD[7:1]) k = nxe_pkg::K_EXD;
		else if (op[7:3] == nxe_pkg::OPC_XOR_REG[7:3]) k = nxe_pkg::K_XOR_REG;
		else if (op == nxe_pkg::OPC_XOR_DIR) k = nxe_pkg::K_XOR_DIR;
		else if (op[7:1] == nxe_pkg::OPC_XOR_IND[7:1]) k = nxe_pkg::K_XOR_IND;
		else if (op == nxe_pkg::OPC_XOR_IMM) k = nxe_pkg::K_XOR_IMM;
		else if (op == nxe_pkg::OPC_XOR_DA) k = nxe_pkg::K_XOR_DA;
		else if (op == nxe_pkg::OPC_XOR_DI) k = nxe_pkg::K_XOR_DI;
		return k;
	endfunction

	// Bytes in high pair, machine cycles in low pair
	function automatic logic [3:0] form_len(input nxe_pkg::nxe_kind_e k);
		logic [3:0] r;
		r = 4'h5;
		case (k)
			nxe_pkg::K_SBW_IMM, nxe_pkg::K_EXB_DIR, nxe_pkg::K_XOR_DIR,
			nxe_pkg::K_XOR_IMM, nxe_pkg::K_XOR_DA: r = 4'h9;
			nxe_pkg::K_XOR_DI: r = 4'he;
			nxe_pkg::K_BAD: r = 4'h0;
			default: r = 4'h5;
		endcase
		return r;
	endfunction

	// Result and flags of acc - b - c, packed as carry, aux, overflow, result
	function automatic logic [10:0] sbw_calc(input logic [7:0] a, input logic [7:0] b, input logic c);
		logic [8:0] full;
		logic [4:0] low4;
		logic [7:0] low7;
		full = {1'b0, a} - {1'b0, b} - {8'h00, c};
		low4 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
		low7 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c};
		return {full[8], low4[4], low7[7] ^ full[8], full[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// State and latched instruction fields
	// ----------------------------------------------------------------
	nxe_pkg::nxe_state_e st;
	nxe_pkg::nxe_state_e next_st;
	nxe_pkg::nxe_kind_e kind;
	logic [7:0] ea;
	logic [7:0] imm1;
	logic [7:0] imm2;
	logic illegal_op;
	logic [7:0] mem_rdata;

	// Decode of the incoming opcode
	nxe_pkg::nxe_kind_e new_kind;
	logic new_ind;
	logic new_reg;
	logic new_mem;
	logic [7:0] idle_addr;
	logic take;
	assign new_kind = decode_kind(opcode);
	assign new_ind = new_kind == nxe_pkg::K_EXB_IND || new_kind == nxe_pkg::K_EXD
		|| new_kind == nxe_pkg::K_XOR_IND;
	assign new_reg = new_kind == nxe_pkg::K_EXB_REG || new_kind == nxe_pkg::K_XOR_REG;
	assign new_mem = !(new_kind == nxe_pkg::K_SBW_IMM || new_kind == nxe_pkg::K_SWAP
		|| new_kind == nxe_pkg::K_XOR_IMM || new_kind == nxe_pkg::K_BAD);
	assign take = start && st == nxe_pkg::ST_IDLE;
	// Bank register, pointer register or direct address for the first read
	assign idle_addr = new_reg ? {5'h00, opcode[2:0]}
		: new_ind ? {7'h00, opcode[0]}
		: operand1;

	// ----------------------------------------------------------------
	// Operand routing
	// ----------------------------------------------------------------
	logic is_dir;
	logic to_port;
	logic rmw;
	logic writes_mem;
	logic [7:0] mem_raddr;
	logic mem_rd_en;
	logic [7:0] opnd;
	logic [10:0] sub_res;
	assign is_dir = kind == nxe_pkg::K_EXB_DIR || kind == nxe_pkg::K_XOR_DIR
		|| kind == nxe_pkg::K_XOR_DA || kind == nxe_pkg::K_XOR_DI;
	assign to_port = is_dir && ea == PORT_ADDR;
	// Read-modify-write forms take the port latch; plain reads see the pins
	assign rmw = kind == nxe_pkg::K_XOR_DA || kind == nxe_pkg::K_XOR_DI;
	assign writes_mem = rmw || kind == nxe_pkg::K_EXB_REG || kind == nxe_pkg::K_EXB_DIR
		|| kind == nxe_pkg::K_EXB_IND || kind == nxe_pkg::K_EXD;
	// Second read uses the pointer just returned by the RAM
	assign mem_raddr = st == nxe_pkg::ST_PTR ? mem_rdata : idle_addr;
	assign mem_rd_en = (take && new_mem) || st == nxe_pkg::ST_PTR;
	assign opnd = (kind == nxe_pkg::K_SBW_IMM || kind == nxe_pkg::K_XOR_IMM) ? imm1
		: !to_port ? mem_rdata
		: rmw ? port_out : port_pins;
	assign sub_res = sbw_calc(acc, opnd, carry);

	// Result values written in the execute state
	logic [7:0] next_acc;
	logic [7:0] wr_data;
	logic exec_we;
	logic mem_we;
	logic port_we;
	always_comb begin
		next_acc = acc;
		wr_data = acc;
		case (kind)
			nxe_pkg::K_SBW_IMM: next_acc = sub_res[7:0];
			nxe_pkg::K_SWAP: next_acc = {acc[3:0], acc[7:4]};
			nxe_pkg::K_EXB_REG, nxe_pkg::K_EXB_DIR, nxe_pkg::K_EXB_IND: next_acc = opnd;
			nxe_pkg::K_EXD: begin
				next_acc = {acc[7:4], opnd[3:0]};
				wr_data = {opnd[7:4], acc[3:0]};
			end
			nxe_pkg::K_XOR_REG, nxe_pkg::K_XOR_DIR, nxe_pkg::K_XOR_IND,
			nxe_pkg::K_XOR_IMM: next_acc = acc ^ opnd;
			nxe_pkg::K_XOR_DA: wr_data = opnd ^ acc;
			nxe_pkg::K_XOR_DI: wr_data = opnd ^ imm2;
			default: next_acc = acc;
		endcase
	end
	assign exec_we = st == nxe_pkg::ST_EXEC && writes_mem;
	assign mem_we = exec_we && !to_port;
	assign port_we = exec_we && to_port;

	nxe_ram u_ram (
		.clk(clk),
		.rst(rst),
		.rd_en(mem_rd_en),
		.raddr(mem_raddr),
		.rdata(mem_rdata),
		.we(mem_we),
		.waddr(ea),
		.wdata(wr_data)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		case (st)
			nxe_pkg::ST_IDLE: if (start) next_st = new_kind == nxe_pkg::K_BAD ? nxe_pkg::ST_FIN
				: new_ind ? nxe_pkg::ST_PTR : nxe_pkg::ST_EXEC;
			nxe_pkg::ST_PTR: next_st = nxe_pkg::ST_EXEC;
			nxe_pkg::ST_EXEC: next_st = nxe_pkg::ST_FIN;
			nxe_pkg::ST_FIN: next_st = nxe_pkg::ST_IDLE;
			default: next_st = nxe_pkg::ST_IDLE;
		endcase
	end
	assign busy = st != nxe_pkg::ST_IDLE;
	assign done = st == nxe_pkg::ST_FIN;
	assign illegal = done && illegal_op;

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= nxe_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Instruction fields captured on the start cycle; pointer resolves the address later
	always_ff @(posedge clk) begin
		if (rst) begin
			kind <= nxe_pkg::K_BAD;
			ea <= 8'h00;
			imm1 <= 8'h00;
			imm2 <= 8'h00;
			illegal_op <= 1'b0;
			{instr_bytes, instr_cycles} <= 4'h0;
		end else if (take) begin
			kind <= new_kind;
			ea <= idle_addr;
			imm1 <= operand1;
			imm2 <= operand2;
			illegal_op <= new_kind == nxe_pkg::K_BAD;
			{instr_bytes, instr_cycles} <= form_len(new_kind);
		end else if (st == nxe_pkg::ST_PTR) begin
			ea <= mem_rdata;
		end
	end

	// Architectural state; borrow subtract sets all three flags, the idle load sets carry only
	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= nxe_pkg::ACC_RST;
			{carry, aux_carry_flag, overflow_flag} <= 3'h0;
		end else if (st == nxe_pkg::ST_EXEC) begin
			acc <= next_acc;
			if (kind == nxe_pkg::K_SBW_IMM) begin
				{carry, aux_carry_flag, overflow_flag} <= sub_res[10:8];
			end
		end else if (ld_en && st == nxe_pkg::ST_IDLE) begin
			acc <= ld_acc;
			carry <= ld_carry;
		end
	end

	// Output port latch
	always_ff @(posedge clk) begin
		if (rst) begin
			port_out <= nxe_pkg::PORT_RST;
		end else if (port_we) begin
			port_out <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Flag properties restate the borrow rules on their own, not through the subtract helper
	a_sbw_result: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SBW_IMM) |=>
		acc == 8'($past(acc) - $past(imm1) - {7'h00, $past(carry)})) else $error("subtract result wrong");
	a_sbw_borrow: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SBW_IMM) |=>
		carry == ({1'b0, $past(acc)} < {1'b0, $past(imm1)} + {8'h00, $past(carry)})) else $error("borrow flag wrong");
	a_sbw_aux: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SBW_IMM) |=>
		aux_carry_flag == ({1'b0, $past(acc[3:0])} < {1'b0, $past(imm1[3:0])} + {4'h0, $past(carry)}))
		else $error("aux carry flag wrong");
	a_sbw_overflow: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SBW_IMM) |=>
		overflow_flag == (carry ^ ({1'b0, $past(acc[6:0])} < {1'b0, $past(imm1[6:0])} + {7'h00, $past(carry)})))
		else $error("overflow flag wrong");
	a_swap_nibbles: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SWAP) |=>
		acc == {$past(acc[3:0]), $past(acc[7:4])} && $stable(carry)) else $error("nibble swap wrong");
	a_exb_both: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_EXB_IND) |->
		(mem_we && wr_data == acc) ##1 (acc == $past(opnd))) else $error("exchange not mutual");
	a_exb_reg: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_EXB_REG) |->
		(mem_we && wr_data == acc && ea[7:3] == 5'h00) ##1 (acc == $past(opnd))) else $error("register exchange wrong");
	a_reg_select: assert property ((take && opcode[7:3] == 5'b11001) |->
		mem_rd_en && mem_raddr == {5'h00, opcode[2:0]}) else $error("bank register select wrong");
	a_digit_swap: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_EXD) |->
		wr_data == {opnd[7:4], acc[3:0]} ##1 acc == {$past(acc[7:4]), $past(opnd[3:0])}) else $error("digit exchange wrong");
	a_xor_noflags: assert property ((st == nxe_pkg::ST_EXEC && kind != nxe_pkg::K_SBW_IMM) |=>
		$stable(carry) && $stable(aux_carry_flag) && $stable(overflow_flag)) else $error("flags changed");
	a_port_latch: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_XOR_DA && to_port) |=>
		port_out == ($past(port_out) ^ $past(acc))) else $error("port xor used pins");
	a_dir_mask: assert property ((st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_XOR_DI && !to_port) |->
		mem_we && wr_data == (mem_rdata ^ imm2) && ea == $past(operand1)) else $error("mask complement wrong");
	a_dir_source: assert property ((take && opcode == 8'h65) |-> mem_raddr == operand1 ##1
		st == nxe_pkg::ST_EXEC ##1 done) else $error("direct source form wrong");
	a_form_len: assert property ((take && opcode == 8'h63) |=> instr_bytes == 2'd3 && instr_cycles == 2'd2)
		else $error("form length wrong");
	a_ptr_select: assert property ((take && opcode[7:1] == 7'h6b) |->
		mem_raddr == {7'h00, opcode[0]} ##1 st == nxe_pkg::ST_PTR ##2 done) else $error("pointer select wrong");

	c_swap: cover property (st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SWAP);
	c_exb_ind: cover property (st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_EXB_IND);
	c_digit_swap: cover property (st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_EXD);
	c_port_xor: cover property (port_we && kind == nxe_pkg::K_XOR_DI);
	c_sbw_overflow: cover property (st == nxe_pkg::ST_EXEC && kind == nxe_pkg::K_SBW_IMM && sub_res[8]);

endmodule

/* File: tb_nxe_exec.sv */
// Self-checking testbench for the exchange, swap, borrow subtract and xor datapath.
// Assumes the datapath carries its own assertions; the bench drives every port directly.
`timescale 1ns/1ns
module tb_nxe_exec;
	logic clk, rst, start, ld_en, ld_carry;
	logic [7:0] opcode, operand1, operand2, ld_acc, port_pins;
	logic busy, done, illegal, carry, aux_carry_flag, overflow_flag;
	logic [7:0] acc, port_out, v;
	logic [1:0] instr_bytes, instr_cycles;
	int fail_count, cmp_count;

	nxe_exec i_nxe_exec (.clk(clk), .rst(rst), .start(start), .opcode(opcode), .operand1(operand1),
		.operand2(operand2), .ld_en(ld_en), .ld_acc(ld_acc), .ld_carry(ld_carry), .port_pins(port_pins),
		.busy(busy), .done(done), .illegal(illegal), .acc(acc), .carry(carry),
		.aux_carry_flag(aux_carry_flag), .overflow_flag(overflow_flag), .port_out(port_out),
		.instr_bytes(instr_bytes), .instr_cycles(instr_cycles));

	// ----------------------------------------------------------------
	// Clock, compare and bus tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Case inequality so an unknown never passes as a match
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Flags packed as carry, aux carry, overflow
	task automatic chk_flags(input logic [2:0] exp);
		chk("flags", {5'h00, exp}, {5'h00, carry, aux_carry_flag, overflow_flag});
	endtask

	// Accumulator and carry load happens only while idle
	task automatic ld(input logic [7:0] a, input logic c);
		@(posedge clk);
		ld_en <= 1'b1;
		ld_acc <= a;
		ld_carry <= c;
		@(posedge clk);
		ld_en <= 1'b0;
	endtask

	// One instruction: latency counted from the taking edge, sampled mid-cycle once done is up
	task automatic run(input logic [7:0] op, o1, o2, input logic [1:0] eb, ec, input int lat);
		int n;
		@(posedge clk);
		start <= 1'b1;
		opcode <= op;
		operand1 <= o1;
		operand2 <= o2;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (n < 8 && done !== 1'b1);
		chk("latency", lat[7:0], n[7:0]);
		chk("illegal", {7'h00, eb == 2'h0}, {7'h00, illegal});
		chk("bytes", {6'h00, eb}, {6'h00, instr_bytes});
		chk("cycles", {6'h00, ec}, {6'h00, instr_cycles});
	endtask

	// RAM access goes through the block itself, since RAM is not reset
	task automatic wr(input logic [7:0] a, d);
		ld(d, 1'b0);
		run(8'hc5, a, 8'h00, 2'h2, 2'h1, 2);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		ld(8'h00, 1'b0);
		run(8'h65, a, 8'h00, 2'h2, 2'h1, 2);
		d = acc;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("acc", 8'h00, acc);
		chk("port_out", 8'hff, port_out);
		chk("busy", 8'h00, {7'h00, busy});
		chk_flags(3'b000);
	endtask

	// Borrow cases: overflow without borrow, borrow through every bit, and a sign flip with a bit 3 borrow
	task automatic t_sbw;
		ld(8'hc9, 1'b1);
		run(8'h94, 8'h54, 8'h00, 2'h2, 2'h1, 2);
		chk("acc", 8'h74, acc);
		chk_flags(3'b001);
		ld(8'h00, 1'b0);
		run(8'h94, 8'h01, 8'h00, 2'h2, 2'h1, 2);
		chk("acc", 8'hff, acc);
		chk_flags(3'b110);
		ld(8'h80, 1'b0);
		run(8'h94, 8'h01, 8'h00, 2'h2, 2'h1, 2);
		chk("acc", 8'h7f, acc);
		chk_flags(3'b011);
	endtask

	task automatic t_swap;
		ld(8'hc5, 1'b1);
		run(8'hc4, 8'h00, 8'h00, 2'h1, 2'h1, 2);
		chk("acc", 8'h5c, acc);
		chk_flags(3'b111);
	endtask

	// First pass fills all eight bank registers, second pass reads them back by exchange
	task automatic t_exb_reg;
		for (int r = 0; r < 8; r++) begin
			ld(8'ha0 + 8'(r), 1'b0);
			run(8'hc8 | 8'(r), 8'h00, 8'h00, 2'h1, 2'h1, 2);
		end
		for (int r = 0; r < 8; r++) begin
			ld(8'h40 + 8'(r), 1'b0);
			run(8'hc8 | 8'(r), 8'h00, 8'h00, 2'h1, 2'h1, 2);
			chk("acc", 8'ha0 + 8'(r), acc);
		end
	endtask

	task automatic t_exb_ind;
		wr(8'h00, 8'h20);
		wr(8'h20, 8'h75);
		ld(8'h3f, 1'b0);
		run(8'hc6, 8'h00, 8'h00, 2'h1, 2'h1, 3);
		chk("acc", 8'h75, acc);
		rd(8'h20, v);
		chk("ram", 8'h3f, v);
	endtask

	// Pointer 1 selected by opcode bit 0; flags must survive the exchange
	task automatic t_exd;
		wr(8'h01, 8'h21);
		wr(8'h21, 8'h75);
		ld(8'h36, 1'b1);
		run(8'hd7, 8'h00, 8'h00, 2'h1, 2'h1, 3);
		chk("acc", 8'h35, acc);
		chk_flags(3'b111);
		rd(8'h21, v);
		chk("ram", 8'h76, v);
	endtask

	task automatic t_xor;
		wr(8'h00, 8'haa);
		ld(8'hc3, 1'b1);
		run(8'h68, 8'h00, 8'h00, 2'h1, 2'h1, 2);
		chk("acc", 8'h69, acc);
		chk_flags(3'b111);
		wr(8'h05, 8'h0f);
		ld(8'hf0, 1'b0);
		run(8'h6d, 8'h00, 8'h00, 2'h1, 2'h1, 2);
		chk("acc", 8'hff, acc);
		ld(8'hff, 1'b0);
		run(8'h67, 8'h00, 8'h00, 2'h1, 2'h1, 3);
		chk("acc", 8'h89, acc);
		ld(8'hc3, 1'b0);
		run(8'h64, 8'h3c, 8'h00, 2'h2, 2'h1, 2);
		chk("acc", 8'hff, acc);
		wr(8'h30, 8'h55);
		ld(8'h0f, 1'b0);
		run(8'h65, 8'h30, 8'h00, 2'h2, 2'h1, 2);
		chk("acc", 8'h5a, acc);
		ld(8'hf0, 1'b0);
		run(8'h62, 8'h30, 8'h00, 2'h2, 2'h1, 2);
		rd(8'h30, v);
		chk("ram", 8'ha5, v);
		run(8'h63, 8'h30, 8'hff, 2'h3, 2'h2, 2);
		rd(8'h30, v);
		chk("ram", 8'h5a, v);
		chk_flags(3'b011);
	endtask

	// Pins held opposite to the latch, so a read of the pins shows at once
	task automatic t_port;
		@(posedge clk);
		port_pins <= 8'h00;
		run(8'h63, 8'h90, 8'h31, 2'h3, 2'h2, 2);
		chk("port_out", 8'hce, port_out);
		ld(8'h0f, 1'b0);
		run(8'h62, 8'h90, 8'h00, 2'h2, 2'h1, 2);
		chk("port_out", 8'hc1, port_out);
		@(posedge clk);
		port_pins <= 8'h5a;
		ld(8'h00, 1'b0);
		run(8'h65, 8'h90, 8'h00, 2'h2, 2'h1, 2);
		chk("acc", 8'h5a, acc);
	endtask

	// Start and load are held up through a whole swap; both must be dropped while busy
	task automatic t_refuse;
		ld(8'h3c, 1'b0);
		@(posedge clk);
		start <= 1'b1;
		opcode <= 8'hc4;
		@(posedge clk);
		opcode <= 8'h64;
		operand1 <= 8'hff;
		ld_en <= 1'b1;
		ld_acc <= 8'h00;
		@(posedge clk);
		@(posedge clk);
		start <= 1'b0;
		ld_en <= 1'b0;
		@(negedge clk);
		chk("acc", 8'hc3, acc);
		chk("busy", 8'h00, {7'h00, busy});
	endtask

	task automatic t_illegal;
		ld(8'h12, 1'b0);
		run(8'h00, 8'h00, 8'h00, 2'h0, 2'h0, 1);
		chk("acc", 8'h12, acc);
	endtask

	// ----------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// The whole run needs well under a thousand cycles
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		start = 1'b0;
		ld_en = 1'b0;
		ld_carry = 1'b0;
		opcode = 8'h00;
		operand1 = 8'h00;
		operand2 = 8'h00;
		ld_acc = 8'h00;
		port_pins = 8'hff;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_sbw();
		t_swap();
		t_exb_reg();
		t_exb_ind();
		t_exd();
		t_xor();
		t_port();
		t_refuse();
		t_illegal();
		end_of_test();
	end
endmodule
